// file: core/rcts_pkg.sv
/*
  Package for the reference clock trim, clock status and fast RC self-tune block.
  Holds register offsets, field positions, codes and timing counts.
  Assumes a 50 MHz bus clock and 32-bit APB.
*/
package rcts_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_REF_CON  = 8'h00;
  localparam logic [7:0] OFF_REF_TRIM = 8'h04;
  localparam logic [7:0] OFF_STATUS   = 8'h08;
  localparam logic [7:0] OFF_TUNE     = 8'h0c;
  localparam logic [7:0] OFF_UNLOCK   = 8'h10;
  localparam logic [7:0] OFF_TUNE_ST  = 8'h14;

  // Reference control fields
  localparam int REF_DIV_LSB   = 16;
  localparam int REF_DIV_W     = 15;
  localparam int REF_ON_BIT    = 15;
  localparam int REF_STOP_IN_IDLE_BIT  = 13;
  localparam int REF_OE_BIT    = 12;
  localparam int REF_REFCLK_RUN_IN_SLEEP_BIT  = 11;
  localparam int REF_SWREQ_BIT = 9;
  localparam int REF_ACT_BIT   = 8;
  localparam int REF_SEL_W     = 4;

  // Trim field
  localparam int TRIM_LSB = 23;
  localparam int TRIM_W   = 9;

  // Status bits
  localparam int ST_PLL_LOCK  = 7;
  localparam int ST_USB       = 6;
  localparam int ST_LOW_POWER_RC_OSCILLATOR      = 5;
  localparam int ST_SECONDARY_OSCILLATOR      = 4;
  localparam int ST_PRIMARY_OSCILLATOR      = 2;
  localparam int ST_PLLDIV    = 1;
  localparam int ST_FRC       = 0;
  localparam int ST_RSVD_ONE  = 8;

  // Tuning register fields
  localparam int TUN_ON_BIT    = 15;
  localparam int TUN_STOP_IN_IDLE_BIT  = 13;
  localparam int TUN_SRC_BIT   = 12;
  localparam int TUN_LOCK_BIT  = 11;
  localparam int TUN_POL_BIT   = 10;
  localparam int TUN_TUNE_OUT_OF_RANGE_BIT  = 9;
  localparam int TUN_RANGE_IRQ_POLARITY_BIT = 8;
  localparam int TUN_W         = 6;

  // Source select codes
  localparam logic [3:0] SEL_SYSTEM_CLOCK = 4'h0;
  localparam logic [3:0] SEL_PRIMARY_OSCILLATOR   = 4'h2;
  localparam logic [3:0] SEL_FRC    = 4'h3;
  localparam logic [3:0] SEL_LOW_POWER_RC_OSCILLATOR   = 4'h4;
  localparam logic [3:0] SEL_SECONDARY_OSCILLATOR   = 4'h5;
  localparam logic [3:0] SEL_VCO    = 4'h7;

  // Unlock keys, values arbitrary
  localparam logic [31:0] UNLOCK_KEY1 = 32'haa99_6655;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h5566_99aa;

  // Tuning code limits
  localparam logic [5:0] TUN_MAX = 6'h1f;
  localparam logic [5:0] TUN_MIN = 6'h20;

  // Self-tune window and lock band (0.2 % of 8 MHz window counts)
  localparam int WIN_REF_EDGES   = 16;
  localparam int LOCK_TOL_PERMIL = 2;
  localparam int FRC_PER_WIN     = 4096;
  localparam logic [15:0] FRC_EXPECT = 16'(FRC_PER_WIN);
  localparam logic [15:0] LOCK_TOL   = 16'(FRC_PER_WIN * LOCK_TOL_PERMIL / 1000);
  localparam logic [15:0] RANGE_TOL  = 16'(FRC_PER_WIN * 3 / 100);
endpackage

// file: core/rcts_top.sv
/*
  Reference clock source/trim control, clock-ready status and fast RC self-tune
  loop behind an APB slave. Oscillators, PLL and divider datapath sit outside;
  their ready levels, edge strobes and power-mode flags arrive synchronous to I_CLK.
*/
`timescale 1ns/1ps
module rcts_top (
  // Clock, reset, enable
  input  wire logic        I_CLK,
  input  wire logic        I_RST_B,
  input  wire logic        I_CE,
  // APB slave
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  // Oscillator status levels
  input  wire logic        I_PLL_LOCK_READY,
  input  wire logic        I_USB_OSC_READY,
  input  wire logic        I_LOW_POWER_RC_OSCILLATOR_EN,
  input  wire logic        I_FRC_EN,
  input  wire logic        I_SECONDARY_OSCILLATOR_EN,
  input  wire logic        I_SECONDARY_OSCILLATOR_OST_DONE,
  input  wire logic        I_PRIMARY_OSCILLATOR_EN,
  input  wire logic        I_PRIMARY_OSCILLATOR_OST_DONE,
  input  wire logic        I_PLLDIV_EN,
  input  wire logic        I_PLLDIV_TMR_DONE,
  // Power modes and reference divider handshake
  input  wire logic        I_IDLE,
  input  wire logic        I_SLEEP,
  input  wire logic        I_REF_ACTIVE,
  input  wire logic        I_REF_OUT_EDGE,
  // Self-tune edge strobes
  input  wire logic        I_FRC_TICK,
  input  wire logic        I_USB_REF_TICK,
  input  wire logic        I_SECONDARY_OSCILLATOR_REF_TICK,
  // Reference divider controls
  output logic [3:0]       O_REF_SOURCE_SELECT,
  output logic [14:0]      O_REF_INTEGER_DIVIDER,
  output logic [8:0]       O_REF_FRACTION_TRIM,
  output logic             O_REF_ENABLE,
  output logic             O_REF_PIN_OE,
  output logic             O_REF_RUN,
  // Fast RC tuning
  output logic [5:0]       O_FAST_RC_TUNE_CODE,
  output logic             O_LOCK_IRQ,
  output logic             O_RANGE_IRQ
);
  logic        acc_w, acc_r;
  logic        ref_on_q, ref_stop_in_idle_q, ref_oe_q, ref_refclk_run_in_sleep_q, sw_req_q;
  logic [3:0]  sel_q;
  logic [14:0] div_q;
  logic [8:0]  trim_q;
  logic [1:0]  unlk_q;
  logic        tune_on_q, tune_stop_in_idle_q, tune_src_q, lock_pol_q, rng_pol_q;
  logic        lock_q, tune_out_of_range_q;
  logic [5:0]  tun_q;
  logic [15:0] frc_cnt_q;
  logic [4:0]  ref_cnt_q;
  logic        tune_run;
  logic        ref_tick;
  logic [31:0] rd_d;
  logic        unlocked;

  assign acc_w    = I_PSEL & I_PENABLE & I_PWRITE & I_CE;
  assign acc_r    = I_PSEL & I_PENABLE & ~I_PWRITE & I_CE;
  assign unlocked = unlk_q == 2'd2;

  // Reference control register
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      ref_on_q   <= 1'b0;
      ref_stop_in_idle_q <= 1'b0;
      ref_oe_q   <= 1'b0;
      ref_refclk_run_in_sleep_q <= 1'b0;
      sel_q      <= 4'h0;
      div_q      <= 15'h0000;
    end else if (acc_w && I_PADDR == rcts_pkg::OFF_REF_CON) begin
      ref_on_q   <= I_PWDATA[rcts_pkg::REF_ON_BIT];
      ref_stop_in_idle_q <= I_PWDATA[rcts_pkg::REF_STOP_IN_IDLE_BIT];
      ref_oe_q   <= I_PWDATA[rcts_pkg::REF_OE_BIT];
      ref_refclk_run_in_sleep_q <= I_PWDATA[rcts_pkg::REF_REFCLK_RUN_IN_SLEEP_BIT];
      sel_q      <= I_PWDATA[rcts_pkg::REF_SEL_W-1:0];
      div_q      <= I_PWDATA[rcts_pkg::REF_DIV_LSB +: rcts_pkg::REF_DIV_W];
    end
  end

  // Divider switch request: software sets, hardware clears on an output edge or while the reference is off
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      sw_req_q <= 1'b0;
    end else if (I_CE) begin
      if (acc_w && I_PADDR == rcts_pkg::OFF_REF_CON && I_PWDATA[rcts_pkg::REF_SWREQ_BIT]) begin
        sw_req_q <= 1'b1;
      end else if (sw_req_q && (!ref_on_q || I_REF_OUT_EDGE)) begin
        sw_req_q <= 1'b0;
      end
    end
  end

  // Trim register; applied copy feeds the divider
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      trim_q <= 9'h000;
    end else if (acc_w && I_PADDR == rcts_pkg::OFF_REF_TRIM) begin
      trim_q <= I_PWDATA[rcts_pkg::TRIM_LSB +: rcts_pkg::TRIM_W];
    end
  end

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_REF_FRACTION_TRIM   <= 9'h000;
      O_REF_INTEGER_DIVIDER <= 15'h0000;
    end else if (I_CE) begin
      // Glitch-free: a running divider only reloads on its own output edge
      if (!ref_on_q || (sw_req_q && I_REF_OUT_EDGE)) begin
        O_REF_INTEGER_DIVIDER <= div_q;
        O_REF_FRACTION_TRIM   <= (div_q == 15'h0000) ? 9'h000 : trim_q;
      end
    end
  end

  // Reference enables toward the divider
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_REF_SOURCE_SELECT <= 4'h0;
      O_REF_ENABLE        <= 1'b0;
      O_REF_PIN_OE        <= 1'b0;
      O_REF_RUN           <= 1'b0;
    end else if (I_CE) begin
      O_REF_SOURCE_SELECT <= sel_q;
      O_REF_ENABLE        <= ref_on_q;
      O_REF_PIN_OE        <= ref_oe_q;
      // System_clock source stops with the core anyway, so run-in-sleep means nothing
      O_REF_RUN <= ref_on_q && !(I_IDLE && ref_stop_in_idle_q)
                   && !(I_SLEEP && (sel_q == rcts_pkg::SEL_SYSTEM_CLOCK || !ref_refclk_run_in_sleep_q));
    end
  end

  // Unlock sequence: two keys, then one tuning write
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      unlk_q <= 2'd0;
    end else if (acc_w) begin
      if (I_PADDR == rcts_pkg::OFF_UNLOCK && I_PWDATA == rcts_pkg::UNLOCK_KEY1) begin
        unlk_q <= 2'd1;
      end else if (I_PADDR == rcts_pkg::OFF_UNLOCK && I_PWDATA == rcts_pkg::UNLOCK_KEY2 && unlk_q == 2'd1) begin
        unlk_q <= 2'd2;
      end else begin
        unlk_q <= 2'd0;
      end
    end
  end

  // Tuning control bits
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tune_on_q   <= 1'b0;
      tune_stop_in_idle_q <= 1'b0;
      tune_src_q  <= 1'b0;
      lock_pol_q  <= 1'b0;
      rng_pol_q   <= 1'b0;
    end else if (acc_w && I_PADDR == rcts_pkg::OFF_TUNE && unlocked) begin
      tune_on_q   <= I_PWDATA[rcts_pkg::TUN_ON_BIT];
      tune_stop_in_idle_q <= I_PWDATA[rcts_pkg::TUN_STOP_IN_IDLE_BIT];
      tune_src_q  <= I_PWDATA[rcts_pkg::TUN_SRC_BIT];
      lock_pol_q  <= I_PWDATA[rcts_pkg::TUN_POL_BIT];
      rng_pol_q   <= I_PWDATA[rcts_pkg::TUN_RANGE_IRQ_POLARITY_BIT];
    end
  end

  assign tune_run = tune_on_q && !(I_IDLE && tune_stop_in_idle_q);
  assign ref_tick = tune_src_q ? I_USB_REF_TICK : I_SECONDARY_OSCILLATOR_REF_TICK;

  // Window counters: fixed count of reference edges, fast RC edges counted
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      frc_cnt_q <= 16'h0000;
      ref_cnt_q <= 5'h00;
    end else if (I_CE) begin
      if (!tune_run) begin
        frc_cnt_q <= 16'h0000;
        ref_cnt_q <= 5'h00;
      end else if (ref_tick && ref_cnt_q == 5'(rcts_pkg::WIN_REF_EDGES - 1)) begin
        frc_cnt_q <= 16'h0000;
        ref_cnt_q <= 5'h00;
      end else begin
        frc_cnt_q <= frc_cnt_q + 16'(I_FRC_TICK);
        ref_cnt_q <= ref_cnt_q + 5'(ref_tick);
      end
    end
  end

  logic        win_end;
  logic        fast, slow;
  logic [15:0] err;
  assign win_end = tune_run && ref_tick && ref_cnt_q == 5'(rcts_pkg::WIN_REF_EDGES - 1);
  assign fast    = frc_cnt_q > rcts_pkg::FRC_EXPECT;
  assign slow    = frc_cnt_q < rcts_pkg::FRC_EXPECT;
  assign err     = fast ? frc_cnt_q - rcts_pkg::FRC_EXPECT : rcts_pkg::FRC_EXPECT - frc_cnt_q;

  // Tuning code: hardware steps it while self-tune is on, else software owns it
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tun_q  <= 6'h00;
      lock_q <= 1'b0;
      tune_out_of_range_q <= 1'b0;
    end else if (I_CE) begin
      if (!tune_on_q) begin
        lock_q <= 1'b0;
        tune_out_of_range_q <= 1'b0;
        if (acc_w && I_PADDR == rcts_pkg::OFF_TUNE && unlocked) begin
          tun_q <= I_PWDATA[rcts_pkg::TUN_W-1:0];
        end
      end else if (win_end) begin
        lock_q <= err <= rcts_pkg::LOCK_TOL;
        tune_out_of_range_q <= err > rcts_pkg::RANGE_TOL;
        if (err > rcts_pkg::LOCK_TOL && err <= rcts_pkg::RANGE_TOL) begin
          // Signed code: saturate at 011111 and 100000
          if (slow && tun_q != rcts_pkg::TUN_MAX) begin
            tun_q <= tun_q + 6'h01;
          end else if (fast && tun_q != rcts_pkg::TUN_MIN) begin
            tun_q <= tun_q - 6'h01;
          end
        end
      end
    end
  end

  // Tuning code and interrupt levels out
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_FAST_RC_TUNE_CODE <= 6'h00;
      O_LOCK_IRQ          <= 1'b0;
      O_RANGE_IRQ         <= 1'b0;
    end else if (I_CE) begin
      O_FAST_RC_TUNE_CODE <= tun_q;
      O_LOCK_IRQ          <= tune_on_q && (lock_q == !lock_pol_q);
      O_RANGE_IRQ         <= tune_on_q && (tune_out_of_range_q == !rng_pol_q);
    end
  end

  // Read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    case (I_PADDR)
      rcts_pkg::OFF_REF_CON: begin
        rd_d[rcts_pkg::REF_DIV_LSB +: rcts_pkg::REF_DIV_W] = div_q;
        rd_d[rcts_pkg::REF_ON_BIT]    = ref_on_q;
        rd_d[rcts_pkg::REF_STOP_IN_IDLE_BIT]  = ref_stop_in_idle_q;
        rd_d[rcts_pkg::REF_OE_BIT]    = ref_oe_q;
        rd_d[rcts_pkg::REF_REFCLK_RUN_IN_SLEEP_BIT]  = ref_refclk_run_in_sleep_q;
        rd_d[rcts_pkg::REF_SWREQ_BIT] = sw_req_q;
        rd_d[rcts_pkg::REF_ACT_BIT]   = I_REF_ACTIVE;
        rd_d[3:0]                     = sel_q;
      end
      rcts_pkg::OFF_REF_TRIM: begin
        rd_d[rcts_pkg::TRIM_LSB +: rcts_pkg::TRIM_W] = trim_q;
      end
      rcts_pkg::OFF_STATUS: begin
        rd_d[rcts_pkg::ST_RSVD_ONE] = 1'b1;
        rd_d[rcts_pkg::ST_PLL_LOCK] = I_PLL_LOCK_READY;
        rd_d[rcts_pkg::ST_USB]      = I_USB_OSC_READY;
        rd_d[rcts_pkg::ST_LOW_POWER_RC_OSCILLATOR]     = I_LOW_POWER_RC_OSCILLATOR_EN;
        rd_d[rcts_pkg::ST_FRC]      = I_FRC_EN;
        rd_d[rcts_pkg::ST_SECONDARY_OSCILLATOR]     = I_SECONDARY_OSCILLATOR_EN & I_SECONDARY_OSCILLATOR_OST_DONE;
        rd_d[rcts_pkg::ST_PRIMARY_OSCILLATOR]     = I_PRIMARY_OSCILLATOR_EN & I_PRIMARY_OSCILLATOR_OST_DONE;
        rd_d[rcts_pkg::ST_PLLDIV]   = I_PLLDIV_EN & I_PLLDIV_TMR_DONE;
      end
      rcts_pkg::OFF_TUNE: begin
        rd_d[rcts_pkg::TUN_ON_BIT]    = tune_on_q;
        rd_d[rcts_pkg::TUN_STOP_IN_IDLE_BIT]  = tune_stop_in_idle_q;
        rd_d[rcts_pkg::TUN_SRC_BIT]   = tune_src_q;
        rd_d[rcts_pkg::TUN_LOCK_BIT]  = lock_q;
        rd_d[rcts_pkg::TUN_POL_BIT]   = lock_pol_q;
        rd_d[rcts_pkg::TUN_TUNE_OUT_OF_RANGE_BIT]  = tune_out_of_range_q;
        rd_d[rcts_pkg::TUN_RANGE_IRQ_POLARITY_BIT] = rng_pol_q;
        rd_d[rcts_pkg::TUN_W-1:0]     = tun_q;
      end
      rcts_pkg::OFF_TUNE_ST: begin
        rd_d[1:0] = unlk_q;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  // APB answer: zero wait states, error on unmapped or misaligned address
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PRDATA  <= 32'h0000_0000;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end else if (I_CE) begin
      O_PREADY  <= I_PSEL & ~I_PENABLE;
      O_PSLVERR <= I_PSEL & ~I_PENABLE & (I_PADDR > rcts_pkg::OFF_TUNE_ST || I_PADDR[1:0] != 2'b00);
      O_PRDATA  <= (I_PSEL & ~I_PENABLE & ~I_PWRITE) ? rd_d : O_PRDATA;
    end
  end

  logic unused_r;
  assign unused_r = acc_r;

  // Assertions
  AST_SWREQ_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_CE && sw_req_q && ref_on_q && !I_REF_OUT_EDGE && !acc_w |=> sw_req_q)
    else $error("switch request dropped early");
  AST_DIV_ONLY_EDGE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    ref_on_q && $past(ref_on_q) && $changed(O_REF_FRACTION_TRIM) |-> $past(sw_req_q && I_REF_OUT_EDGE))
    else $error("trim applied without switch edge");
  AST_TRIM_ZERO: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    O_REF_INTEGER_DIVIDER == 15'h0000 |-> O_REF_FRACTION_TRIM == 9'h000)
    else $error("trim with zero divider");
  AST_RUN_SLEEP: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_CE && I_SLEEP && sel_q == rcts_pkg::SEL_SYSTEM_CLOCK |=> !O_REF_RUN)
    else $error("system_clock reference ran in sleep");
  AST_TUNE_HOLD: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    tune_on_q && !win_end |=> $stable(tun_q))
    else $error("tune code moved outside window");
  AST_STEP_ONE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    tune_on_q && $past(tune_on_q) && $changed(tun_q) |-> (tun_q - $past(tun_q) == 6'h01) || ($past(tun_q) - tun_q == 6'h01))
    else $error("tune step not one code");
  AST_IDLE_STOP: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_IDLE && tune_stop_in_idle_q |-> !win_end)
    else $error("tuning ran in idle");
  AST_NO_TUNE_TUNE_OUT_OF_RANGE: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    win_end && I_CE && err > rcts_pkg::RANGE_TOL |=> tune_out_of_range_q && $stable(tun_q))
    else $error("tuned while out of range");
  AST_LOCK_IRQ: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_CE && tune_on_q && lock_q != lock_pol_q |=> O_LOCK_IRQ)
    else $error("lock irq missing");
  AST_RANGE_IRQ: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    I_CE && tune_on_q && tune_out_of_range_q != rng_pol_q |=> O_RANGE_IRQ)
    else $error("range irq missing");
  AST_LOCKED_WR: assert property (@(posedge I_CLK) disable iff (!I_RST_B)
    !tune_on_q && !unlocked |=> $stable(tun_q))
    else $error("tune write without unlock");
  COV_SWITCH: cover property (@(posedge I_CLK) disable iff (!I_RST_B) sw_req_q ##1 !sw_req_q);
  COV_LOCK: cover property (@(posedge I_CLK) disable iff (!I_RST_B) !lock_q ##1 lock_q);
  COV_TUNE_OUT_OF_RANGE: cover property (@(posedge I_CLK) disable iff (!I_RST_B) tune_out_of_range_q);
endmodule // rcts_top

// file: tb/rcts_top_test.sv
/*
  Self-checking bench for rcts_top: APB access, clock status, divider and trim, self-tune loop.
  Assumes rcts_pkg is compiled first; oscillator strobes and handshakes are driven here.
*/
`timescale 1ns/1ps
module rcts_top_test;
  logic        clk, rst_b, psel, pen, pwr, refact, refedge, idle, frc_t, usb_t, secondary_oscillator_t, ce, slp;
  logic        pready, pslverr, ren, roe, rrun, lirq, rirq, err_q, usb_on, secondary_oscillator_on;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [3:0]  rsel;
  logic [14:0] rdiv;
  logic [8:0]  rtrim;
  logic [5:0]  tcode, cap;
  logic [9:0]  st_v;
  int          n_fail, cmp_count, cyc, frc_gap, ref_per;

  rcts_top u_dut (
    .I_CLK(clk), .I_RST_B(rst_b), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_PLL_LOCK_READY(st_v[0]), .I_USB_OSC_READY(st_v[1]), .I_LOW_POWER_RC_OSCILLATOR_EN(st_v[2]), .I_FRC_EN(st_v[3]),
    .I_SECONDARY_OSCILLATOR_EN(st_v[4]), .I_SECONDARY_OSCILLATOR_OST_DONE(st_v[5]), .I_PRIMARY_OSCILLATOR_EN(st_v[6]), .I_PRIMARY_OSCILLATOR_OST_DONE(st_v[7]),
    .I_PLLDIV_EN(st_v[8]), .I_PLLDIV_TMR_DONE(st_v[9]), .I_IDLE(idle), .I_SLEEP(slp),
    .I_REF_ACTIVE(refact), .I_REF_OUT_EDGE(refedge), .I_FRC_TICK(frc_t), .I_USB_REF_TICK(usb_t),
    .I_SECONDARY_OSCILLATOR_REF_TICK(secondary_oscillator_t), .O_REF_SOURCE_SELECT(rsel), .O_REF_INTEGER_DIVIDER(rdiv),
    .O_REF_FRACTION_TRIM(rtrim), .O_REF_ENABLE(ren), .O_REF_PIN_OE(roe), .O_REF_RUN(rrun),
    .O_FAST_RC_TUNE_CODE(tcode), .O_LOCK_IRQ(lirq), .O_RANGE_IRQ(rirq));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Strobes: fast RC misses one tick in frc_gap, reference ticks every ref_per cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    frc_t <= (frc_gap == 0) || (cyc % frc_gap != 0);
    usb_t <= usb_on && (cyc % ref_per == 0);
    secondary_oscillator_t <= secondary_oscillator_on && (cyc % ref_per == 0);
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      results();
    end
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  // Unlock is spent by the next write, so every tuning write gets its own
  task automatic twr(input logic [31:0] d);
    wr(rcts_pkg::OFF_UNLOCK, rcts_pkg::UNLOCK_KEY1);
    wr(rcts_pkg::OFF_UNLOCK, rcts_pkg::UNLOCK_KEY2);
    wr(rcts_pkg::OFF_TUNE, d);
  endtask

  task automatic idle_n(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wait_chg(input int bound);
    logic [5:0] c;
    int n;
    c = tcode;
    n = 0;
    while (tcode === c && n < bound) begin
      @(posedge clk);
      n++;
    end
    if (tcode === c) begin
      n_fail++;
      results();
    end
    idle_n(2);
  endtask

  task automatic t_bus();
    rd(8'h18);
    chk("unmapped err", 32'h1, 32'(err_q));
    chk("unmapped data", 32'h0, rd_q);
    rd(8'h02);
    chk("misaligned err", 32'h1, 32'(err_q));
  endtask

  task automatic t_status();
    logic [31:0] e;
    for (int i = 0; i <= 10; i++) begin
      st_v <= (i == 10) ? 10'h3ff : 10'(1 << i);
      idle_n(3);
      rd(rcts_pkg::OFF_STATUS);
      e = 32'h100 | {st_v[0], st_v[1], st_v[2], st_v[4] & st_v[5], 1'b0, st_v[6] & st_v[7], st_v[8] & st_v[9], st_v[3]};
      chk("status", e, rd_q);
    end
  endtask

  task automatic t_ref();
    logic [3:0] codes [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h7};
    foreach (codes[k]) begin
      wr(rcts_pkg::OFF_REF_CON, {28'h0, codes[k]});
      idle_n(2);
      chk("source select", 32'(codes[k]), 32'(rsel));
    end
    wr(rcts_pkg::OFF_REF_TRIM, 32'hffff_ffff);
    rd(rcts_pkg::OFF_REF_TRIM);
    chk("trim readback", 32'hff80_0000, rd_q);
    idle_n(2);
    chk("trim, zero divider", 32'h0, 32'(rtrim));
    wr(rcts_pkg::OFF_REF_CON, 32'h0005_0003);
    idle_n(2);
    chk("trim out", 32'h1ff, 32'(rtrim));
    wr(rcts_pkg::OFF_REF_CON, 32'h0005_8003);
    refact <= 1'b1;
    idle_n(2);
    chk("enable", 32'h1, 32'(ren));
    wr(rcts_pkg::OFF_REF_TRIM, 32'h5280_0000);
    idle_n(4);
    chk("trim pending", 32'h1ff, 32'(rtrim));
    wr(rcts_pkg::OFF_REF_CON, 32'h0009_8203);
    idle_n(3);
    chk("divider early", 32'h5, 32'(rdiv));
    rd(rcts_pkg::OFF_REF_CON);
    chk("switch busy", 32'h1, 32'(rd_q[9]));
    refedge <= 1'b1;
    @(posedge clk);
    refedge <= 1'b0;
    idle_n(2);
    chk("trim at edge", 32'h0a5, 32'(rtrim));
    chk("divider at edge", 32'h9, 32'(rdiv));
    rd(rcts_pkg::OFF_REF_CON);
    chk("switch done", 32'h0, 32'(rd_q[9]));
    wr(rcts_pkg::OFF_REF_CON, 32'h0009_0003);
    refact <= 1'b0;
  endtask

  // Sleep gating, pin enable and clock-enable freeze; request active follows enable
  task automatic t_run();
    wr(rcts_pkg::OFF_REF_CON, 32'h0000_9805);
    refact <= 1'b1;
    slp <= 1'b1;
    idle_n(2);
    chk("run in sleep", 32'h1, 32'(rrun));
    chk("pin enable", 32'h1, 32'(roe));
    wr(rcts_pkg::OFF_REF_CON, 32'h0);
    refact <= 1'b0;
    wr(rcts_pkg::OFF_REF_CON, 32'h0000_9800);
    refact <= 1'b1;
    idle_n(2);
    chk("system_clock sleep stop", 32'h0, 32'(rrun));
    ce <= 1'b0;
    slp <= 1'b0;
    idle_n(3);
    chk("frozen by enable", 32'h0, 32'(rrun));
    ce <= 1'b1;
    idle_n(2);
    chk("run after wake", 32'h1, 32'(rrun));
    wr(rcts_pkg::OFF_REF_CON, 32'h0);
    refact <= 1'b0;
  endtask

  task automatic t_tune();
    wr(rcts_pkg::OFF_TUNE, 32'h15);
    rd(rcts_pkg::OFF_TUNE);
    chk("tune locked", 32'h0, rd_q);
    twr(32'h1e);
    wr(rcts_pkg::OFF_TUNE, 32'h05);
    rd(rcts_pkg::OFF_TUNE);
    chk("tune sw", 32'h1e, rd_q);
    frc_gap <= 43;
    usb_on <= 1'b1;
    twr(32'h0000_951e);
    wait_chg(10000);
    chk("code max", 32'h1f, 32'(tcode));
    chk("lock irq", 32'h1, 32'(lirq));
    chk("range irq", 32'h1, 32'(rirq));
    twr(32'h0000_9505);
    idle_n(9000);
    chk("code held", 32'h1f, 32'(tcode));
    frc_gap <= 2;
    idle_n(9000);
    rd(rcts_pkg::OFF_TUNE);
    chk("out of range", 32'h1, 32'(rd_q[9]));
    chk("range irq off", 32'h0, 32'(rirq));
    // Fast clock is applied only once idle stop is in force
    twr(32'h0000_b500);
    idle <= 1'b1;
    frc_gap <= 0;
    ref_per <= 260;
    idle_n(9000);
    chk("idle hold", 32'h1f, 32'(tcode));
    idle <= 1'b0;
    wait_chg(10000);
    chk("step down", 32'h1e, 32'(tcode));
    twr(32'h0000_8500);
    idle_n(4);
    cap = tcode;
    idle_n(9000);
    chk("no secondary_oscillator ticks", 32'(cap), 32'(tcode));
    usb_on <= 1'b0;
    secondary_oscillator_on <= 1'b1;
    wait_chg(10000);
    chk("secondary_oscillator step", 32'(cap - 6'h1), 32'(tcode));
    ref_per <= 256;
    idle_n(9000);
    rd(rcts_pkg::OFF_TUNE);
    chk("lock", 32'h1, 32'(rd_q[11]));
    chk("lock irq off", 32'h0, 32'(lirq));
  endtask

  initial begin
    rst_b = 1'b0;
    {psel, pen, pwr, refact, refedge, idle, frc_t, usb_t, secondary_oscillator_t, usb_on, secondary_oscillator_on} = 11'h0;
    ce = 1'b1;
    slp = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    st_v = 10'h0;
    cyc = 0;
    frc_gap = 1;
    ref_per = 256;
    n_fail = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(rcts_pkg::OFF_STATUS);
    chk("status reset", 32'h100, rd_q);
    chk("code reset", 32'h0, 32'(tcode));
    t_bus();
    t_status();
    t_ref();
    t_run();
    t_tune();
    results();
  end
endmodule // rcts_top_test
